// >>> shared/fpg_params.svh
`ifndef FPG_PARAMS_SVH
`define FPG_PARAMS_SVH
`define FPG_OFF_CTRL1 8'h00
`define FPG_OFF_CTRL2 8'h04
`define FPG_OFF_GUARD 8'h08
`define FPG_OFF_IEN 8'h20
`define FPG_OFF_FLAGS 8'h24
`define FPG_OFF_FCLR 8'h28
`define FPG_OFF_SECSET 8'h30
`define FPG_KEY 16'h5a5a
`define FPG_KEY_HI 31
`define FPG_KEY_LO 16
`define FPG_MODE_HI 1
`define FPG_MODE_LO 0
`define FPG_STANDBY_BIT 4
`define FPG_BUSY_BIT 5
`define FPG_SEC_HI 7
`define FPG_SEC_LO 6
`define FPG_WAIT_HI 2
`define FPG_FLG_PC 0
`define FPG_FLG_LOCK 1
`define FPG_FLG_WRITE_NOT_BLANK_FLAG 4
`define FPG_CTRL1_RST 32'h0000_0010
`define FPG_GUARD_RST 16'h0000
`define FPG_PAGE_LSB 9
`define FPG_GROUP_LSB 12
`define FPG_ADDR_W 16
`define FPG_BUSY_NS 1000
`define FPG_CLK_MHZ 25
`define FPG_BUSY_CYC ((`FPG_BUSY_NS * `FPG_CLK_MHZ + 999) / 1000)
`define FPG_ERASED 8'hff
`endif

// >>> shared/fpg_pkg.sv
package fpg_pkg;
    typedef enum logic [1:0]
    {
        FPG_MODE_READ = 2'b00,
        FPG_MODE_WRITE_NOT_BLANK_FLAG = 2'b01,
        FPG_MODE_PERASE = 2'b10,
        FPG_MODE_CERASE = 2'b11
    } fpg_mode_e;
    typedef enum logic [1:0]
    {
        FPG_ST_IDLE = 2'b00,
        FPG_ST_CHECK = 2'b01,
        FPG_ST_WORK = 2'b10,
        FPG_ST_WIPE = 2'b11
    } fpg_state_e;
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } fpg_reg_req_s;
    typedef struct packed
    {
        logic req;
        logic [15:0] addr;
        logic [1:0] size;
        logic [31:0] wdata;
    } fpg_flash_wr_s;
endpackage : fpg_pkg

// >>> src/fpg_array_mem.sv
`timescale 1ns/1ps
// Byte-wide array, 32-bit ports; byte lanes make storage little-endian
module fpg_array_mem #(
    parameter int AW = 16
) (
    input wire logic clk,
    input wire logic [AW-3:0] waddr,
    input wire logic [3:0] wbe,
    input wire logic [31:0] wdata,
    input wire logic [AW-3:0] raddr,
    output logic [31:0] rdata
);
    logic [31:0] rdata_r;
    assign rdata = rdata_r;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            // One array per lane, so every array has a single writing process
            logic [7:0] lane_mem [0:(1<<(AW-2))-1];
            always_ff @(posedge clk)
            begin
                if (wbe[gi])
                    lane_mem[waddr] <= wdata[8*gi +: 8];
                rdata_r[8*gi +: 8] <= lane_mem[raddr];
            end
        end
    endgenerate
endmodule : fpg_array_mem

// >>> src/fpg_guard.sv
`timescale 1ns/1ps
`include "fpg_params.svh"
// Functional notes
// - 128 pages, 16 lock bits; bit n covers pages 8n..8n+7.
// - Page erase or program allowed only where the group bit is 1; chip erase ignores the group bits.
// - Keyed registers ignore writes whose upper half is not the key.
// - Operation on locked group abandoned, locked-page flag set.
// - Interrupt asserted while any flag set with its enable bit 1.
// - Writing 0 to a clear-register bit clears that flag.
// - Nonzero level refuses debug and bootloader reads, whole array.
// - Level reported in a read-only two-bit field.
// - CPU fetches and data reads served at every level.
// - Level codes: 00 open, 01/10/11 protected levels 1-3.
// - Level 1 downgradable via bootloader or debug, array erased.
// - Level 2 downgradable only via bootloader, array erased.
// - Level 3 refuses every downgrade.
// - Fetch from flash stalled while busy.
// - Multi-byte data stored little-endian.
// - Standby bit 1 puts array low-power in deep sleep.
// - Mode field: 00 read, 01 program, 10 page erase, 11 chip erase.
// - Program fails with programming-error flag unless targeted bytes all ones.
module fpg_guard
    import fpg_pkg::*;
#(
    parameter int BUSY_CYC = `FPG_BUSY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic fl_wr,
    input wire logic [15:0] fl_wr_addr,
    input wire logic [1:0] fl_wr_size,
    input wire logic [31:0] fl_wr_data,
    input wire logic [15:0] cpu_pc,
    input wire logic pc_in_flash,
    input wire logic fl_rd,
    input wire logic [15:0] fl_rd_addr,
    input wire logic [1:0] fl_rd_src,
    output logic [31:0] fl_rdata,
    output logic fl_rd_refused,
    output logic fetch_stall,
    output logic irq,
    input wire logic deep_sleep_state,
    output logic array_low_power,
    input wire logic [1:0] level_load,
    input wire logic level_load_en,
    input wire logic downgrade_req,
    input wire logic downgrade_from_debug,
    output logic downgrade_refused
);
    localparam int CW = $clog2(BUSY_CYC + 1) + 16;
    logic [1:0] mode_r;
    logic standby_r;
    logic [2:0] wait_r;
    logic [15:0] guard_r;
    logic [4:0] ien_r;
    logic [4:0] flags_r;
    logic [1:0] level_r;
    fpg_state_e state_r;
    logic [CW-1:0] cnt_r;
    fpg_flash_wr_s op_r;
    logic [31:0] rdata_r;
    logic rd_refused_r;
    logic rd_pend_r;
    logic key_ok;
    logic group_open;
    logic same_page;
    logic [3:0] be;
    logic blank;
    logic [31:0] mem_rdata;
    logic [13:0] mem_waddr;
    logic [13:0] mem_raddr;
    logic [3:0] mem_wbe;
    logic [31:0] mem_wdata;
    logic [4:0] set_flags;
    logic start_op;
    logic ext_src;
    logic busy;

    assign key_ok = reg_wdata[`FPG_KEY_HI:`FPG_KEY_LO] == `FPG_KEY;
    assign group_open = guard_r[op_r.addr[`FPG_GROUP_LSB +: 4]];
    assign same_page = pc_in_flash && (cpu_pc[15:`FPG_PAGE_LSB] == op_r.addr[15:`FPG_PAGE_LSB]);

    always_comb
    begin
        case (op_r.size)
            2'b00: be = 4'b0001 << op_r.addr[1:0];
            2'b01: be = op_r.addr[1] ? 4'b1100 : 4'b0011;
            default: be = 4'b1111;
        endcase
    end

    always_comb
    begin
        blank = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i] && mem_rdata[8*i +: 8] != `FPG_ERASED)
                blank = 1'b0;
        end
    end

    // checks one cycle after trigger, in the check cycle
    always_comb
    begin
        set_flags = '0;
        start_op = 1'b0;
        if (state_r == FPG_ST_CHECK)
        begin
            if (op_r.size == 2'b11)
                start_op = 1'b1;
            else if (!group_open)
                set_flags[`FPG_FLG_LOCK] = 1'b1;
            else if (same_page)
                set_flags[`FPG_FLG_PC] = 1'b1;
            else if (mode_r == FPG_MODE_WRITE_NOT_BLANK_FLAG && !blank)
                set_flags[`FPG_FLG_WRITE_NOT_BLANK_FLAG] = 1'b1;
            else
                start_op = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= FPG_ST_IDLE;
            cnt_r <= '0;
            op_r <= '0;
        end
        else
        begin
            case (state_r)
                FPG_ST_IDLE:
                begin
                    if (downgrade_req && level_r != 2'b00 && !downgrade_refused)
                    begin
                        // Drop any stale request so the wipe covers the whole array
                        op_r.req <= 1'b0;
                        state_r <= FPG_ST_WIPE;
                        cnt_r <= '0;
                    end
                    else if (fl_wr && mode_r != FPG_MODE_READ)
                    begin
                        op_r.addr <= fl_wr_addr;
                        op_r.wdata <= fl_wr_data;
                        op_r.size <= (mode_r == FPG_MODE_WRITE_NOT_BLANK_FLAG) ? fl_wr_size : 2'b10;
                        op_r.req <= 1'b1;
                        if (mode_r == FPG_MODE_CERASE)
                        begin
                            op_r.size <= 2'b11;
                            op_r.addr <= '0;
                        end
                        state_r <= FPG_ST_CHECK;
                    end
                end
                FPG_ST_CHECK:
                begin
                    cnt_r <= '0;
                    state_r <= start_op ? ((op_r.size == 2'b11 || mode_r != FPG_MODE_WRITE_NOT_BLANK_FLAG) ?
                        FPG_ST_WIPE : FPG_ST_WORK) : FPG_ST_IDLE;
                    if (op_r.size != 2'b11 && mode_r == FPG_MODE_PERASE)
                        op_r.addr <= {op_r.addr[15:`FPG_PAGE_LSB], {`FPG_PAGE_LSB{1'b0}}};
                end
                FPG_ST_WORK:
                begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r >= CW'(BUSY_CYC - 1))
                        state_r <= FPG_ST_IDLE;
                end
                FPG_ST_WIPE:
                begin
                    // Page erase walks one page, chip erase and downgrade the whole array
                    cnt_r <= cnt_r + 1'b1;
                    if ((op_r.size != 2'b11 && op_r.req && cnt_r[6:0] == 7'h7f) || cnt_r[13:0] == 14'h3fff)
                    begin
                        state_r <= FPG_ST_IDLE;
                        op_r.req <= 1'b0;
                    end
                end
                default: state_r <= FPG_ST_IDLE;
            endcase
        end
    end

    always_comb
    begin
        mem_waddr = op_r.addr[15:2];
        mem_wbe = '0;
        mem_wdata = op_r.wdata << (8 * op_r.addr[1:0]);
        if (state_r == FPG_ST_WORK && cnt_r == '0)
            mem_wbe = be;
        else if (state_r == FPG_ST_WIPE)
        begin
            mem_wbe = 4'hf;
            mem_wdata = {4{`FPG_ERASED}};
            mem_waddr = (op_r.req && op_r.size != 2'b11) ?
                {op_r.addr[15:`FPG_PAGE_LSB], cnt_r[6:0]} : cnt_r[13:0];
        end
    end

    assign mem_raddr = (state_r == FPG_ST_IDLE && fl_wr) ? fl_wr_addr[15:2] : fl_rd_addr[15:2];

    fpg_array_mem #(
        .AW(`FPG_ADDR_W)
    ) u_mem (
        .clk(clk),
        .waddr(mem_waddr),
        .wbe(mem_wbe),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // Register writes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_r <= 2'(`FPG_CTRL1_RST);
            standby_r <= 1'(`FPG_CTRL1_RST >> `FPG_STANDBY_BIT);
            wait_r <= '0;
            guard_r <= `FPG_GUARD_RST;
            ien_r <= '0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `FPG_OFF_CTRL1:
                begin
                    if (key_ok)
                    begin
                        mode_r <= reg_wdata[`FPG_MODE_HI:`FPG_MODE_LO];
                        standby_r <= reg_wdata[`FPG_STANDBY_BIT];
                    end
                end
                `FPG_OFF_CTRL2:
                begin
                    if (key_ok)
                        wait_r <= reg_wdata[`FPG_WAIT_HI:0];
                end
                `FPG_OFF_GUARD:
                begin
                    if (key_ok)
                        guard_r <= reg_wdata[15:0];
                end
                `FPG_OFF_IEN: ien_r <= {reg_wdata[4], 2'b00, reg_wdata[1:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            flags_r <= '0;
        else if (reg_wr && reg_addr == `FPG_OFF_FCLR)
            flags_r <= (flags_r & {reg_wdata[4], 2'b00, reg_wdata[1:0]}) | set_flags;
        else
            flags_r <= flags_r | set_flags;
    end

    assign irq = |(flags_r & ien_r);

    // level changes only from load or wipe
    always_ff @(posedge clk)
    begin
        if (rst)
            level_r <= 2'b00;
        else if (level_load_en)
            level_r <= level_load;
        else if (state_r == FPG_ST_WIPE && !op_r.req && cnt_r[13:0] == 14'h3fff)
            level_r <= 2'b00;
    end

    // downgrade refusal, debug barred at level 2
    always_comb
    begin
        downgrade_refused = 1'b0;
        if (downgrade_req)
        begin
            case (level_r)
                2'b01: downgrade_refused = 1'b0;
                2'b10: downgrade_refused = downgrade_from_debug;
                2'b11: downgrade_refused = 1'b1;
                default: downgrade_refused = 1'b0;
            endcase
        end
    end

    // external reads refused at nonzero level, CPU always served
    assign ext_src = fl_rd_src != 2'b00;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_pend_r <= 1'b0;
            rd_refused_r <= 1'b0;
        end
        else
        begin
            rd_pend_r <= fl_rd;
            rd_refused_r <= fl_rd && ext_src && level_r != 2'b00;
        end
    end
    assign fl_rdata = (rd_pend_r && !rd_refused_r) ? mem_rdata : '0;
    assign fl_rd_refused = rd_refused_r;

    // busy only once the checks have passed
    assign busy = state_r == FPG_ST_WORK || state_r == FPG_ST_WIPE;
    assign fetch_stall = busy && pc_in_flash;
    assign array_low_power = standby_r && deep_sleep_state;

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_r <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                `FPG_OFF_CTRL1: rdata_r <= {24'h0, level_r, busy, standby_r, 2'b00, mode_r};
                `FPG_OFF_CTRL2: rdata_r <= {29'h0, wait_r};
                `FPG_OFF_GUARD: rdata_r <= {16'h0, guard_r};
                `FPG_OFF_IEN: rdata_r <= {27'h0, ien_r};
                `FPG_OFF_FLAGS: rdata_r <= {27'h0, flags_r};
                default: rdata_r <= '0;
            endcase
        end
        else
            rdata_r <= '0;
    end
    assign reg_rdata = rdata_r;
endmodule : fpg_guard

// >>> verif/fpg_cpu_model.sv
`timescale 1ns/1ps
module fpg_cpu_model
    import fpg_pkg::*;
(
    input wire logic clk,
    output fpg_flash_wr_s fw,
    output logic [15:0] cpu_pc,
    output logic pc_in_flash,
    output logic fl_rd,
    output logic [15:0] fl_rd_addr,
    output logic [1:0] fl_rd_src
);
    initial
    begin
        fw = '0;
        cpu_pc = 16'h0;
        pc_in_flash = 1'h0;
        fl_rd = 1'h0;
        fl_rd_addr = 16'h0;
        fl_rd_src = 2'h0;
    end
    task automatic set_pc(input logic [15:0] pc, input logic inf);
        @(posedge clk);
        cpu_pc <= pc;
        pc_in_flash <= inf;
    endtask : set_pc
    task automatic store(input logic [15:0] a, input logic [1:0] sz, input logic [31:0] d);
        @(posedge clk);
        fw <= '{req: 1'h1, addr: a & ~((16'h1 << sz) - 16'h1), size: sz, wdata: d};
        @(posedge clk);
        // Released lines inverted so stale data cannot pass
        fw <= '{req: 1'h0, addr: ~a, size: sz, wdata: ~d};
        repeat (2) @(posedge clk);
        #1;
    endtask : store
    task automatic load(input logic [15:0] a, input logic [1:0] src);
        @(posedge clk);
        fl_rd <= 1'h1;
        fl_rd_addr <= a;
        fl_rd_src <= src;
        @(posedge clk);
        fl_rd <= 1'h0;
        fl_rd_addr <= ~a;
        #1;
    endtask : load
endmodule : fpg_cpu_model

// >>> verif/fpg_guard_asserts.sv
`timescale 1ns/1ps
module fpg_guard_asserts
    import fpg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic fl_rd,
    input wire logic [1:0] fl_rd_src,
    input wire logic [31:0] fl_rdata,
    input wire logic fl_rd_refused,
    input wire logic pc_in_flash,
    input wire logic fetch_stall,
    input wire logic deep_sleep_state,
    input wire logic array_low_power,
    input wire logic [1:0] level_load,
    input wire logic level_load_en,
    input wire logic downgrade_req,
    input wire logic downgrade_from_debug,
    input wire logic downgrade_refused
);
    // Level mirror; untrusted after a granted downgrade until reloaded
    logic [1:0] lvl_r;
    logic lvl_ok_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lvl_r <= 2'h0;
            lvl_ok_r <= 1'h1;
        end
        else if (level_load_en)
        begin
            lvl_r <= level_load;
            lvl_ok_r <= 1'h1;
        end
        else if (downgrade_req && !downgrade_refused)
            lvl_ok_r <= 1'h0;
    end
    sequence ext_read;
        fl_rd && fl_rd_src != 2'h0;
    endsequence
    sequence dg_at(logic [1:0] l);
        downgrade_req && lvl_ok_r && lvl_r == l;
    endsequence
    a_ext_refused: assert property (ext_read ##0 (lvl_ok_r && lvl_r != 2'h0) |=> fl_rd_refused)
        else $error("external read served");
    a_refused_zero: assert property (fl_rd_refused |-> fl_rdata == 32'h0)
        else $error("refused read leaks data");
    a_cpu_read: assert property (fl_rd && fl_rd_src == 2'h0 |=> !fl_rd_refused)
        else $error("cpu read refused");
    a_open_read: assert property (fl_rd && lvl_ok_r && lvl_r == 2'h0 |=> !fl_rd_refused)
        else $error("open level read refused");
    a_lvl_three: assert property (dg_at(2'h3) |-> downgrade_refused)
        else $error("level 3 downgraded");
    a_lvl_two_debug: assert property (dg_at(2'h2) ##0 downgrade_from_debug |-> downgrade_refused)
        else $error("level 2 debug downgrade");
    a_lvl_one_open: assert property (dg_at(2'h1) |-> !downgrade_refused)
        else $error("level 1 downgrade refused");
    a_stall_flash: assert property (!pc_in_flash |-> !fetch_stall)
        else $error("stall outside flash");
    a_sleep_power: assert property (!deep_sleep_state |-> !array_low_power)
        else $error("low power while awake");
endmodule : fpg_guard_asserts
bind fpg_guard fpg_guard_asserts chk (.clk, .rst, .fl_rd, .fl_rd_src, .fl_rdata, .fl_rd_refused, .pc_in_flash,
    .fetch_stall, .deep_sleep_state, .array_low_power, .level_load, .level_load_en, .downgrade_req,
    .downgrade_from_debug, .downgrade_refused);

// >>> verif/tb_fpg_guard.sv
`timescale 1ns/1ps
module tb_fpg_guard
    import fpg_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    fpg_reg_req_s rq = '0;
    fpg_flash_wr_s fw;
    logic deep_sleep_state = 1'h0;
    logic [1:0] level_load = 2'h0;
    logic level_load_en = 1'h0;
    logic downgrade_req = 1'h0;
    logic downgrade_from_debug = 1'h0;
    logic [31:0] reg_rdata, fl_rdata;
    logic [15:0] cpu_pc, fl_rd_addr;
    logic [1:0] fl_rd_src;
    logic pc_in_flash, fl_rd, fl_rd_refused, fetch_stall, irq, array_low_power, downgrade_refused;
    int n_errors = 0;
    int samples_checked = 0;
    fpg_guard uut (
        .clk, .rst, .reg_wr(rq.wr), .reg_rd(rq.rd), .reg_addr(rq.addr), .reg_wdata(rq.wdata), .reg_rdata,
        .fl_wr(fw.req), .fl_wr_addr(fw.addr), .fl_wr_size(fw.size), .fl_wr_data(fw.wdata), .cpu_pc, .pc_in_flash,
        .fl_rd, .fl_rd_addr, .fl_rd_src, .fl_rdata, .fl_rd_refused, .fetch_stall, .irq, .deep_sleep_state,
        .array_low_power, .level_load, .level_load_en, .downgrade_req, .downgrade_from_debug, .downgrade_refused
    );
    fpg_cpu_model cpu (.clk, .fw, .cpu_pc, .pc_in_flash, .fl_rd, .fl_rd_addr, .fl_rd_src);
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk32
    task automatic chk1(input logic g, input logic e, input string m);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %0t %s got %b", $time, m, g);
        end
    endtask : chk1
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        rq <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        rq <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
        #1;
    endtask : wreg
    task automatic creg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rq <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
        @(posedge clk);
        rq <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 32'hffff_ffff};
        #1;
        chk32(reg_rdata, e, "register");
    endtask : creg
    task automatic wait_idle(input int lim);
        int i;
        i = 0;
        do
        begin
            @(posedge clk);
            rq <= '{wr: 1'h0, rd: 1'h1, addr: 8'h00, wdata: 32'h0};
            @(posedge clk);
            rq <= '0;
            #1;
            i++;
        end
        while (reg_rdata[5] !== 1'h0 && i < lim);
        if (reg_rdata[5] !== 1'h0)
        begin
            n_errors++;
            $display("MISMATCH %0t busy stuck", $time);
            wrap_up();
        end
    endtask : wait_idle
    task automatic cfl(input logic [15:0] a, input logic [1:0] s, input logic [31:0] e, input logic r);
        cpu.load(a, s);
        chk32(fl_rdata, e, "flash data");
        chk1(fl_rd_refused, r, "refusal");
    endtask : cfl
    task automatic setlvl(input logic [1:0] l);
        @(posedge clk);
        level_load <= l;
        level_load_en <= 1'h1;
        @(posedge clk);
        level_load_en <= 1'h0;
    endtask : setlvl
    task automatic dgr(input logic dbg, input logic e);
        @(posedge clk);
        downgrade_req <= 1'h1;
        downgrade_from_debug <= dbg;
        #1;
        chk1(downgrade_refused, e, "downgrade");
        @(posedge clk);
        downgrade_req <= 1'h0;
    endtask : dgr
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        creg(8'h00, 32'h10);
        creg(8'h08, 32'h0);
        creg(8'h20, 32'h0);
        creg(8'h24, 32'h0);
        wreg(8'h08, 32'h0000_0002);
        creg(8'h08, 32'h0);
        wreg(8'h30, 32'h5a5a_ffff);
        creg(8'h30, 32'h0);
        wreg(8'h08, 32'h5a5a_0002);
        creg(8'h08, 32'h2);
        $display("test registers done");
        wreg(8'h00, 32'h5a5a_0012);
        cpu.store(16'h0e00, 2'h2, 32'h0);
        creg(8'h24, 32'h2);
        creg(8'h00, 32'h12);
        chk1(irq, 1'h0, "irq masked");
        wreg(8'h20, 32'h2);
        chk1(irq, 1'h1, "irq raised");
        wreg(8'h28, 32'hffff_fffd);
        creg(8'h24, 32'h0);
        chk1(irq, 1'h0, "irq cleared");
        cpu.set_pc(16'h1100, 1'h1);
        cpu.store(16'h1010, 2'h2, 32'h0);
        creg(8'h24, 32'h1);
        wreg(8'h28, 32'hffff_fffe);
        cpu.set_pc(16'h0100, 1'h1);
        cpu.store(16'h1000, 2'h2, 32'h0);
        chk1(fetch_stall, 1'h1, "stall");
        wait_idle(200);
        chk1(fetch_stall, 1'h0, "stall end");
        cfl(16'h1000, 2'h0, 32'hffff_ffff, 1'h0);
        $display("test erase done");
        wreg(8'h00, 32'h5a5a_0011);
        cpu.set_pc(16'h0100, 1'h0);
        cpu.store(16'h1001, 2'h0, 32'h55);
        wait_idle(100);
        cpu.store(16'h1006, 2'h1, 32'hbeef);
        wait_idle(100);
        cpu.store(16'h1008, 2'h2, 32'h1234_5678);
        wait_idle(100);
        cfl(16'h1000, 2'h0, 32'hffff_55ff, 1'h0);
        cfl(16'h1004, 2'h0, 32'hbeef_ffff, 1'h0);
        cpu.store(16'h1008, 2'h0, 32'haa);
        creg(8'h24, 32'h10);
        cpu.store(16'h0004, 2'h2, 32'h0);
        creg(8'h24, 32'h12);
        cfl(16'h1008, 2'h0, 32'h1234_5678, 1'h0);
        $display("test program done");
        for (int l = 0; l < 4; l++)
        begin
            setlvl(2'(l));
            wreg(8'h00, 32'h5a5a_00d1);
            creg(8'h00, {24'h0, 2'(l), 6'h11});
            for (int s = 0; s < 4; s++)
                cfl(16'h1008, 2'(s), (l != 0 && s != 0) ? 32'h0 : 32'h1234_5678, 1'(l != 0 && s != 0));
        end
        $display("test levels done");
        wreg(8'h00, 32'h5a5a_0013);
        cpu.store(16'h0000, 2'h2, 32'h0);
        wait_idle(9000);
        cfl(16'h1008, 2'h0, 32'hffff_ffff, 1'h0);
        dgr(1'h0, 1'h1);
        dgr(1'h1, 1'h1);
        setlvl(2'h2);
        dgr(1'h1, 1'h1);
        setlvl(2'h1);
        dgr(1'h1, 1'h0);
        wait_idle(9000);
        creg(8'h00, 32'h13);
        cfl(16'h1000, 2'h1, 32'hffff_ffff, 1'h0);
        $display("test downgrade done");
        // idle and read mode before deep sleep
        wreg(8'h00, 32'h5a5a_0010);
        cpu.store(16'h1000, 2'h2, 32'h0);
        cfl(16'h1000, 2'h0, 32'hffff_ffff, 1'h0);
        creg(8'h00, 32'h10);
        @(posedge clk);
        deep_sleep_state <= 1'h1;
        @(posedge clk);
        #1;
        chk1(array_low_power, 1'h1, "standby");
        wreg(8'h00, 32'h5a5a_0000);
        chk1(array_low_power, 1'h0, "awake array");
        $display("test sleep done");
        wrap_up();
    end
endmodule : tb_fpg_guard
